// *** design/tbfsu_pkg.sv ***
package tbfsu_pkg;

	// ---------------------------------------------------------------
	// Widths and limits
	// ---------------------------------------------------------------
	localparam int unsigned WORD_W = 16;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned LEN_W = 8;
	localparam int unsigned BITPOS_W = 4;
	localparam int unsigned TABLE_MAX_WORDS = 255;
	localparam logic [WORD_W-1:0] BIT_ONE = 16'h0001;
	localparam logic [WORD_W-1:0] RESULT_NONE = 16'h0000;

	// ---------------------------------------------------------------
	// Operations and states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_SET_TABLE_BIT,
		OP_CLEAR_TABLE_BIT,
		OP_FILL,
		OP_FIND_EQUAL,
		OP_FIND_GREATER_VALUE
	} tbfsu_op_e;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_WAIT,
		ST_FILL
	} tbfsu_state_e;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		tbfsu_op_e op;
		logic [WORD_W-1:0] stack1;
		logic [WORD_W-1:0] stack2;
		logic [WORD_W-1:0] acc;
		logic [WORD_W-1:0] operand;
	} tbfsu_cmd_s;

	typedef struct packed {
		tbfsu_state_e st;
		tbfsu_op_e op;
		logic [ADDR_W-1:0] base;
		logic [ADDR_W-1:0] addr;
		logic [LEN_W-1:0] len;
		logic [LEN_W-1:0] idx;
		logic [WORD_W-1:0] value;
		logic [BITPOS_W-1:0] bitpos;
		logic [WORD_W-1:0] acc;
		logic flag;
		logic done;
		logic mem_en;
		logic mem_we;
		logic [WORD_W-1:0] wdata;
	} tbfsu_regs_s;

	localparam tbfsu_regs_s REGS_RESET = '{st: ST_IDLE, op: OP_SET_TABLE_BIT, default: '0};

endpackage

// *** design/tbfsu_unit.sv ***
`timescale 1ns/100ps
// What this block does
// - Set-table-bit forces exactly the addressed table bit to one, others kept.
// - Clear-table-bit forces exactly the addressed table bit to zero, others kept.
// - Bit reference counts from table start; the first bit is number zero.
// - Each table word holds 16 bits; references continue across words.
// - A bit reference beyond the table end raises the range flag.
// - Fill writes one value into every word of a table up to 255 words.
// - Equality search returns the offset of the first equal word at or after the start offset.
// - Equality search flags a bad start or no match; no match returns zero.
// - Greater search finds the first word above the search value.
// - Greater search has no offset; length up to 255 sits in stack level one.
// - Greater search returns the offset; no match raises the flag and returns zero.
// - Search results are zero-based offsets from the table start, in the accumulator.
module tbfsu_unit
	import tbfsu_pkg::*;
#(
	parameter int unsigned TABLE_MAX = TABLE_MAX_WORDS
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire tbfsu_cmd_s cmd,
	input wire logic scan_end,
	output logic mem_en,
	output logic mem_we,
	output logic [ADDR_W-1:0] mem_addr,
	output logic [WORD_W-1:0] mem_wdata,
	input wire logic [WORD_W-1:0] mem_rdata,
	output logic done,
	output logic [WORD_W-1:0] acc_out,
	output logic table_range_flag
);

	// ---------------------------------------------------------------
	// Elaboration checks
	// ---------------------------------------------------------------
	if (TABLE_MAX < 1 || TABLE_MAX > TABLE_MAX_WORDS) begin : g_bad_max
		$error("TABLE_MAX must lie between 1 and 255");
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic is_search(input tbfsu_op_e op);
		is_search = (op == OP_FIND_EQUAL) || (op == OP_FIND_GREATER_VALUE);
	endfunction

	// Lengths above the build limit are cut down rather than refused.
	function automatic logic [LEN_W-1:0] clip_len(input logic [WORD_W-1:0] raw);
		if (raw > WORD_W'(TABLE_MAX)) begin
			clip_len = LEN_W'(TABLE_MAX);
		end else begin
			clip_len = raw[LEN_W-1:0];
		end
	endfunction

	tbfsu_regs_s s_reg;
	tbfsu_regs_s s_next;
	logic [WORD_W-BITPOS_W-1:0] word_idx;
	logic hit;

	assign word_idx = cmd.operand[WORD_W-1:BITPOS_W];
	assign hit = (s_reg.op == OP_FIND_EQUAL) ? (mem_rdata == s_reg.value) :
		(mem_rdata > s_reg.value);

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.mem_en = 1'b0;
		s_next.mem_we = 1'b0;
		if (scan_end) begin
			s_next.flag = 1'b0;
		end
		case (s_reg.st)
			ST_IDLE: begin
				if (cmd_valid) begin
					s_next.op = cmd.op;
					s_next.value = cmd.operand;
					s_next.bitpos = cmd.operand[BITPOS_W-1:0];
					s_next.idx = '0;
					case (cmd.op)
						OP_SET_TABLE_BIT, OP_CLEAR_TABLE_BIT: begin
							s_next.base = cmd.acc;
							s_next.len = clip_len(cmd.stack1);
							if (word_idx >= (WORD_W-BITPOS_W)'(clip_len(cmd.stack1))) begin
								s_next.flag = 1'b1;
								s_next.done = 1'b1;
							end else begin
								s_next.addr = cmd.acc + ADDR_W'(word_idx);
								s_next.mem_en = 1'b1;
								s_next.st = ST_READ;
							end
						end
						OP_FILL: begin
							s_next.base = cmd.acc;
							s_next.len = clip_len(cmd.stack1);
							s_next.addr = cmd.acc;
							if (clip_len(cmd.stack1) == '0) begin
								s_next.done = 1'b1;
							end else begin
								s_next.mem_en = 1'b1;
								s_next.mem_we = 1'b1;
								s_next.wdata = cmd.operand;
								s_next.st = ST_FILL;
							end
						end
						OP_FIND_EQUAL: begin
							s_next.base = cmd.stack1;
							s_next.len = clip_len(cmd.stack2);
							if (cmd.acc >= WORD_W'(clip_len(cmd.stack2))) begin
								s_next.flag = 1'b1;
								s_next.acc = RESULT_NONE;
								s_next.done = 1'b1;
							end else begin
								s_next.idx = cmd.acc[LEN_W-1:0];
								s_next.addr = cmd.stack1 + ADDR_W'(cmd.acc[LEN_W-1:0]);
								s_next.mem_en = 1'b1;
								s_next.st = ST_READ;
							end
						end
						OP_FIND_GREATER_VALUE: begin
							s_next.base = cmd.acc;
							s_next.len = clip_len(cmd.stack1);
							s_next.addr = cmd.acc;
							if (clip_len(cmd.stack1) == '0) begin
								s_next.flag = 1'b1;
								s_next.acc = RESULT_NONE;
								s_next.done = 1'b1;
							end else begin
								s_next.mem_en = 1'b1;
								s_next.st = ST_READ;
							end
						end
						default: begin
							s_next.done = 1'b1;
						end
					endcase
				end
			end
			ST_READ: begin
				s_next.st = ST_WAIT;
			end
			ST_WAIT: begin
				if (!is_search(s_reg.op)) begin
					// Read-modify-write keeps every other bit of the word.
					s_next.mem_en = 1'b1;
					s_next.mem_we = 1'b1;
					if (s_reg.op == OP_SET_TABLE_BIT) begin
						s_next.wdata = mem_rdata | (BIT_ONE << s_reg.bitpos);
					end else begin
						s_next.wdata = mem_rdata & ~(BIT_ONE << s_reg.bitpos);
					end
					s_next.flag = 1'b0;
					s_next.done = 1'b1;
					s_next.st = ST_IDLE;
				end else if (hit) begin
					s_next.acc = WORD_W'(s_reg.idx);
					s_next.flag = 1'b0;
					s_next.done = 1'b1;
					s_next.st = ST_IDLE;
				end else if (s_reg.idx + 1'b1 == s_reg.len) begin
					s_next.acc = RESULT_NONE;
					s_next.flag = 1'b1;
					s_next.done = 1'b1;
					s_next.st = ST_IDLE;
				end else begin
					s_next.idx = s_reg.idx + 1'b1;
					s_next.addr = s_reg.addr + 1'b1;
					s_next.mem_en = 1'b1;
					s_next.st = ST_READ;
				end
			end
			ST_FILL: begin
				if (s_reg.idx + 1'b1 == s_reg.len) begin
					s_next.done = 1'b1;
					s_next.st = ST_IDLE;
				end else begin
					s_next.idx = s_reg.idx + 1'b1;
					s_next.addr = s_reg.addr + 1'b1;
					s_next.mem_en = 1'b1;
					s_next.mem_we = 1'b1;
				end
			end
			default: begin
				s_next.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_reg <= REGS_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign cmd_ready = (s_reg.st == ST_IDLE);
	assign mem_en = s_reg.mem_en;
	assign mem_we = s_reg.mem_we;
	assign mem_addr = s_reg.addr;
	assign mem_wdata = s_reg.wdata;
	assign done = s_reg.done;
	assign acc_out = s_reg.acc;
	assign table_range_flag = s_reg.flag;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_set_bit_write: assert property (@(posedge ref_clk) disable iff (reset)
		(s_reg.st == ST_WAIT && s_reg.op == OP_SET_TABLE_BIT) |=>
		mem_we && mem_wdata == ($past(mem_rdata) | (BIT_ONE << $past(s_reg.bitpos))))
		else $error("set bit wrote a wrong word");

	a_clear_bit_write: assert property (@(posedge ref_clk) disable iff (reset)
		(s_reg.st == ST_WAIT && s_reg.op == OP_CLEAR_TABLE_BIT) |=>
		mem_we && mem_wdata == ($past(mem_rdata) & ~(BIT_ONE << $past(s_reg.bitpos))))
		else $error("clear bit wrote a wrong word");

	a_bit_range_flag: assert property (@(posedge ref_clk) disable iff (reset)
		(cmd_valid && cmd_ready && (cmd.op == OP_SET_TABLE_BIT || cmd.op == OP_CLEAR_TABLE_BIT) &&
		word_idx >= (WORD_W-BITPOS_W)'(clip_len(cmd.stack1))) |=> done && table_range_flag && !mem_en)
		else $error("out of range bit reference not flagged");

	a_bit_word_addr: assert property (@(posedge ref_clk) disable iff (reset)
		(cmd_valid && cmd_ready && (cmd.op == OP_SET_TABLE_BIT || cmd.op == OP_CLEAR_TABLE_BIT) &&
		word_idx < (WORD_W-BITPOS_W)'(clip_len(cmd.stack1))) |=>
		mem_en && !mem_we && mem_addr == $past(cmd.acc) + ADDR_W'($past(word_idx)))
		else $error("bit operation read the wrong word");

	a_find_bad_start: assert property (@(posedge ref_clk) disable iff (reset)
		(cmd_valid && cmd_ready && cmd.op == OP_FIND_EQUAL &&
		cmd.acc >= WORD_W'(clip_len(cmd.stack2))) |=> done && table_range_flag && acc_out == '0)
		else $error("bad start offset not flagged");

	a_miss_zero: assert property (@(posedge ref_clk) disable iff (reset)
		(done && table_range_flag && is_search(s_reg.op)) |-> acc_out == RESULT_NONE)
		else $error("missed search returned nonzero");

	a_hit_result: assert property (@(posedge ref_clk) disable iff (reset)
		(s_reg.st == ST_WAIT && is_search(s_reg.op) && hit) |=>
		done && !table_range_flag && acc_out == WORD_W'($past(s_reg.idx)))
		else $error("search hit not reported");

	a_fill_word: assert property (@(posedge ref_clk) disable iff (reset)
		(s_reg.st == ST_FILL) |-> mem_en && mem_we && mem_wdata == s_reg.value)
		else $error("fill wrote a wrong value");

	a_scan_clear: assert property (@(posedge ref_clk) disable iff (reset)
		scan_end |=> (done || !table_range_flag))
		else $error("flag survived scan end");

	a_op_finishes: assert property (@(posedge ref_clk) disable iff (reset)
		(cmd_valid && cmd_ready) |-> ##[1:520] done)
		else $error("operation did not complete");

endmodule

// *** dv/tbfsu_mem_model.sv ***
`timescale 1ns/100ps
module tbfsu_mem_model (
	input wire logic ref_clk,
	input wire logic mem_en,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic [15:0] mem_rdata
);
	logic [15:0] mem [0:255];
	logic rd_q = 1'b0;
	logic [15:0] rdata_q = 16'h0000;

	assign mem_rdata = rdata_q;

	// Read data is good for one cycle only; after that the lines show the inverse
	// so that a late sample cannot pass by luck.
	always @(posedge ref_clk) begin
		rd_q <= mem_en && !mem_we;
		if (mem_en && mem_we) begin
			mem[mem_addr[7:0]] <= mem_wdata;
		end
		if (mem_en && !mem_we) begin
			rdata_q <= mem[mem_addr[7:0]];
		end else if (rd_q) begin
			rdata_q <= ~rdata_q;
		end
	end
endmodule

// *** dv/table_bit_fill_search_unit_tb_top.sv ***
`timescale 1ns/100ps
module table_bit_fill_search_unit_tb_top;
	import tbfsu_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic cmd_valid = 1'b0;
	logic cmd_ready, mem_en, mem_we, done, table_range_flag;
	logic scan_end = 1'b0;
	tbfsu_cmd_s cmd = '0;
	logic [15:0] mem_addr, mem_wdata, mem_rdata, acc_out;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;

	initial forever #25 ref_clk = ~ref_clk;

	tbfsu_unit tbfsu_unit_inst (.ref_clk(ref_clk), .reset(reset), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd(cmd), .scan_end(scan_end), .mem_en(mem_en),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .done(done), .acc_out(acc_out),
		.table_range_flag(table_range_flag));

	tbfsu_mem_model tbfsu_mem_model_inst (.ref_clk(ref_clk), .mem_en(mem_en), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic summarize();
		$display("compares %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Offers one command, then waits for the done pulse under a bound.
	task automatic run(input tbfsu_op_e op, input logic [15:0] s1, s2, a, v);
		int k;
		@(negedge ref_clk);
		cmd = '{op: op, stack1: s1, stack2: s2, acc: a, operand: v};
		cmd_valid = 1'b1;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 600) begin
			@(negedge ref_clk);
			k++;
		end
		chk({15'h0000, done}, 16'h0001);
		chk({15'h0000, cmd_ready}, 16'h0001);
		// A write that leaves with the done pulse lands at the next edge, so wait it out.
		@(negedge ref_clk);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_bits();
		tbfsu_mem_model_inst.mem[8'h10] = 16'hFFFF;
		tbfsu_mem_model_inst.mem[8'h11] = 16'h8000;
		run(OP_SET_TABLE_BIT, 16'h0002, 16'h0000, 16'h0010, 16'h001C);
		chk(tbfsu_mem_model_inst.mem[8'h11], 16'h9000);
		chk(tbfsu_mem_model_inst.mem[8'h10], 16'hFFFF);
		run(OP_CLEAR_TABLE_BIT, 16'h0002, 16'h0000, 16'h0010, 16'h001F);
		chk(tbfsu_mem_model_inst.mem[8'h11], 16'h1000);
		run(OP_CLEAR_TABLE_BIT, 16'h0002, 16'h0000, 16'h0010, 16'h0000);
		chk(tbfsu_mem_model_inst.mem[8'h10], 16'hFFFE);
		chk({15'h0000, table_range_flag}, 16'h0000);
		$display("test bits done");
	endtask

	task automatic t_range();
		run(OP_SET_TABLE_BIT, 16'h0002, 16'h0000, 16'h0010, 16'h0020);
		chk({15'h0000, table_range_flag}, 16'h0001);
		chk(tbfsu_mem_model_inst.mem[8'h10], 16'hFFFE);
		chk(tbfsu_mem_model_inst.mem[8'h11], 16'h1000);
		scan_end = 1'b1;
		@(negedge ref_clk);
		scan_end = 1'b0;
		@(negedge ref_clk);
		chk({15'h0000, table_range_flag}, 16'h0000);
		$display("test range done");
	endtask

	task automatic t_fill();
		tbfsu_mem_model_inst.mem[8'h23] = 16'h1234;
		run(OP_FILL, 16'h0003, 16'h0000, 16'h0020, 16'hA5C3);
		for (int i = 0; i < 3; i++) begin
			chk(tbfsu_mem_model_inst.mem[8'h20 + i], 16'hA5C3);
		end
		chk(tbfsu_mem_model_inst.mem[8'h23], 16'h1234);
		$display("test fill done");
	endtask

	task automatic t_find();
		tbfsu_mem_model_inst.mem[8'h30] = 16'h0005;
		tbfsu_mem_model_inst.mem[8'h31] = 16'h0007;
		tbfsu_mem_model_inst.mem[8'h32] = 16'h0009;
		tbfsu_mem_model_inst.mem[8'h33] = 16'h0007;
		run(OP_FIND_EQUAL, 16'h0030, 16'h0004, 16'h0002, 16'h0007);
		chk(acc_out, 16'h0003);
		run(OP_FIND_EQUAL, 16'h0030, 16'h0004, 16'h0000, 16'h0008);
		chk(acc_out, 16'h0000);
		chk({15'h0000, table_range_flag}, 16'h0001);
		run(OP_FIND_EQUAL, 16'h0030, 16'h0004, 16'h0000, 16'h0007);
		chk(acc_out, 16'h0001);
		chk({15'h0000, table_range_flag}, 16'h0000);
		run(OP_FIND_EQUAL, 16'h0030, 16'h0004, 16'h0004, 16'h0007);
		chk(acc_out, 16'h0000);
		chk({15'h0000, table_range_flag}, 16'h0001);
		$display("test find done");
	endtask

	task automatic t_greater();
		run(OP_FIND_GREATER_VALUE, 16'h0004, 16'h0000, 16'h0030, 16'h0007);
		chk(acc_out, 16'h0002);
		chk({15'h0000, table_range_flag}, 16'h0000);
		run(OP_FIND_GREATER_VALUE, 16'h0004, 16'h0000, 16'h0030, 16'h0009);
		chk(acc_out, 16'h0000);
		chk({15'h0000, table_range_flag}, 16'h0001);
		$display("test greater done");
	endtask

	// ---------------------------------------------------------------
	// Main sequence and hang guard
	// ---------------------------------------------------------------
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			summarize();
		end
	end

	initial begin
		repeat (8) @(negedge ref_clk);
		reset = 1'b0;
		t_bits();
		t_range();
		t_fill();
		t_find();
		t_greater();
		summarize();
	end
endmodule
